// *** ucc_defines.svh ***
// Constants for the up/down timer with two edge sense channels.
// What this block does
// - Eleven-bit counter counts up or down as chosen by a control bit.
// - Control bit picks system clock or low-power clock as counter clock.
// - Timer interrupt at max, min or reload threshold, including zero by wrapping.
// - Each channel senses rising or falling edges; falling-edge select 0 means rising.
// - Counting channel interrupts after set edge count, stores elapsed timer cycles.
// - Counting channel restarts the next group at once until timer disabled.
// - Capture channel snapshots timer count or 22-bit RTC value per stamp select.
// - Edge while event pending keeps old value, sets overrun; both clear together.
// - Both channels may select the same pin at once.
// - Per-channel mode bit: 0 capture mode, 1 counting mode.
// - Per-channel interrupt enable gates the channel interrupt.
// - Pin select values 1 to 12 choose pins 0 to 11.
// - Result register holds the value when the channel interrupt appears.
// - Periods measured equal the period field plus one.
// - Counting result equals timer clock cycles over the programmed periods.
// - Timer runs only with clock enable and enable bits both set.
// - Reload field sets the threshold where the counter interrupts and restarts.
`ifndef UCC_DEFINES_SVH
`define UCC_DEFINES_SVH

`define UCC_CNT_W 11
`define UCC_RTC_W 22
`define UCC_PER_W 8
`define UCC_PIN_W 4
`define UCC_GPIO_N 12
`define UCC_ADDR_W 8

`define UCC_OFF_CTRL 8'h00
`define UCC_OFF_CAPTURE 8'h04
`define UCC_OFF_STATUS 8'h08
`define UCC_OFF_COUNT 8'h0c
`define UCC_OFF_RESULT1 8'h10
`define UCC_OFF_RESULT2 8'h14
`define UCC_OFF_CLEAR 8'h18

`define UCC_CTRL_DOWN 11
`define UCC_CTRL_IRQ_EN 12
`define UCC_CTRL_FREE 13
`define UCC_CTRL_SYS_CLK 14
`define UCC_CTRL_CLK_EN 15
`define UCC_CTRL_ENABLE 16

`define UCC_STAT_EVENT 0
`define UCC_STAT_OVERRUN 2

`define UCC_RESP_OKAY 2'b00
`define UCC_RESP_SLVERR 2'b10

`endif

// *** ucc_pkg.sv ***
// Types shared by the up/down timer with two edge sense channels.
`include "ucc_defines.svh"

package ucc_pkg;

	// Per-channel configuration, laid out as one half-word of the capture register.
	typedef struct packed {
		logic channel_falling_edge_select;
		logic channel_counting_mode_select;
		logic channel_irq_enable;
		logic snapshot_source_select;
		logic [`UCC_PIN_W-1:0] channel_pin_select;
		logic [`UCC_PER_W-1:0] measure_period_count;
	} ucc_chcfg_t;

	typedef struct packed {
		logic sense_prev;
		logic channel_event_flag;
		logic channel_overrun_flag;
		logic [`UCC_RTC_W-1:0] channel_result_value;
		logic [`UCC_RTC_W-1:0] cycles;
		logic [`UCC_PER_W-1:0] edges;
	} ucc_chst_t;

	typedef struct packed {
		logic [`UCC_GPIO_N-1:0] gpio_s1;
		logic [`UCC_GPIO_N-1:0] gpio_s2;
		logic lp_s1;
		logic lp_s2;
		logic lp_prev;
		logic [`UCC_CNT_W-1:0] reload_threshold;
		logic count_direction_down;
		logic counter_irq_enable;
		logic free_running_enable;
		logic clock_source_select;
		logic counter_clock_enable;
		logic counter_enable;
		logic [`UCC_CNT_W-1:0] count;
		logic timer_irq;
		ucc_chcfg_t [1:0] cfg;
		ucc_chst_t [1:0] ch;
		logic [1:0] ch_irq;
		logic aw_have;
		logic w_have;
		logic [`UCC_ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ucc_state_t;

endpackage

// *** ucc_timer.sv ***
// Up/down timer with two edge sense channels behind an AXI4-Lite slave.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "ucc_defines.svh"

module ucc_timer
	import ucc_pkg::*;
#(
	parameter int P_GPIO_N = `UCC_GPIO_N
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [`UCC_GPIO_N-1:0] i_gpio,
	input wire logic i_low_power_clock,
	input wire logic [`UCC_RTC_W-1:0] i_rtc_value,
	input wire logic [`UCC_ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [`UCC_ADDR_W-1:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic o_timer_irq,
	output logic [1:0] o_channel_irq
);

	if (P_GPIO_N != `UCC_GPIO_N) begin : g_check
		$error("P_GPIO_N must match the pin select decode width");
	end

	// Refuse constant settings that the register layout cannot hold.
	if (`UCC_CNT_W != `UCC_CTRL_DOWN) begin : g_ctrl_fit
		$error("reload field must end just below the direction bit");
	end

	if (`UCC_CTRL_ENABLE > 31) begin : g_ctrl_top
		$error("control bits must fit one 32-bit word");
	end

	if (`UCC_RTC_W != 22 || `UCC_CNT_W != 11) begin : g_rtc_fit
		$error("read and snapshot padding assume 22-bit results and an 11-bit count");
	end

	if ($bits(ucc_chcfg_t) != 16) begin : g_cfg_fit
		$error("channel configuration must fill one half-word");
	end

	if ((1 << `UCC_PIN_W) <= `UCC_GPIO_N) begin : g_pin_fit
		$error("pin select field cannot reach every pin");
	end

	ucc_state_t s_r;
	ucc_state_t s_nxt;

	function automatic logic pin_level(input logic [`UCC_GPIO_N-1:0] g,
			input logic [`UCC_PIN_W-1:0] sel);
		logic lvl;
		lvl = 1'b0;
		if (sel >= 4'h1 && sel <= 4'hc) begin
			lvl = g[sel - 4'h1];
		end
		return lvl;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return m;
	endfunction

	always_comb begin
		logic run;
		logic tick;
		logic hit;
		logic do_wr;
		logic [1:0] clr;
		logic [31:0] ctrl_word;
		logic [31:0] cap_word;
		logic [31:0] stat_word;
		logic [31:0] m;
		logic [31:0] rd;
		logic [1:0] rresp;
		logic sense;
		logic edge_seen;
		logic pending;
		logic fire;
		logic [`UCC_RTC_W-1:0] val;
		logic [`UCC_RTC_W-1:0] cyc;
		run = 1'b0;
		tick = 1'b0;
		hit = 1'b0;
		do_wr = 1'b0;
		clr = 2'b00;
		m = '0;
		rd = '0;
		rresp = `UCC_RESP_OKAY;
		sense = 1'b0;
		edge_seen = 1'b0;
		pending = 1'b0;
		fire = 1'b0;
		val = '0;
		cyc = '0;
		ctrl_word = '0;
		cap_word = '0;
		stat_word = '0;
		s_nxt = s_r;

		// Pin and low-power clock synchronisers; only the second stage is read.
		s_nxt.gpio_s1 = i_gpio;
		s_nxt.gpio_s2 = s_r.gpio_s1;
		s_nxt.lp_s1 = i_low_power_clock;
		s_nxt.lp_s2 = s_r.lp_s1;
		s_nxt.lp_prev = s_r.lp_s2;

		ctrl_word = {15'h0, s_r.counter_enable, s_r.counter_clock_enable,
			s_r.clock_source_select, s_r.free_running_enable, s_r.counter_irq_enable,
			s_r.count_direction_down, s_r.reload_threshold};
		cap_word = {s_r.cfg[1], s_r.cfg[0]};
		stat_word = {28'h0, s_r.ch[1].channel_overrun_flag, s_r.ch[0].channel_overrun_flag,
			s_r.ch[1].channel_event_flag, s_r.ch[0].channel_event_flag};

		// Write channel: address and data are taken in either order.
		if (i_s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.awaddr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && s_r.wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.wdata = i_s_axi_wdata;
			s_nxt.wstrb = i_s_axi_wstrb;
		end
		if (s_r.bvalid && i_s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		// The write lands one cycle after both halves are held, never while a response waits.
		do_wr = s_r.aw_have && s_r.w_have && !s_r.bvalid;
		if (do_wr) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = `UCC_RESP_OKAY;
			case (s_r.awaddr)
				`UCC_OFF_CTRL: begin
					m = merge(ctrl_word, s_r.wdata, s_r.wstrb);
					s_nxt.reload_threshold = m[`UCC_CNT_W-1:0];
					s_nxt.count_direction_down = m[`UCC_CTRL_DOWN];
					s_nxt.counter_irq_enable = m[`UCC_CTRL_IRQ_EN];
					s_nxt.free_running_enable = m[`UCC_CTRL_FREE];
					s_nxt.clock_source_select = m[`UCC_CTRL_SYS_CLK];
					s_nxt.counter_clock_enable = m[`UCC_CTRL_CLK_EN];
					s_nxt.counter_enable = m[`UCC_CTRL_ENABLE];
				end
				`UCC_OFF_CAPTURE: begin
					m = merge(cap_word, s_r.wdata, s_r.wstrb);
					s_nxt.cfg = m;
				end
				`UCC_OFF_CLEAR: begin
					clr = s_r.wdata[1:0] & {s_r.wstrb[0], s_r.wstrb[0]};
				end
				`UCC_OFF_STATUS, `UCC_OFF_COUNT, `UCC_OFF_RESULT1, `UCC_OFF_RESULT2: begin
					s_nxt.bresp = `UCC_RESP_OKAY;
				end
				default: begin
					s_nxt.bresp = `UCC_RESP_SLVERR;
				end
			endcase
		end
		s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;

		// Read channel: reads have no side effects.
		// The address is decoded as it stands at the accepting edge.
		case (i_s_axi_araddr)
			`UCC_OFF_CTRL: rd = ctrl_word;
			`UCC_OFF_CAPTURE: rd = cap_word;
			`UCC_OFF_STATUS: rd = stat_word;
			`UCC_OFF_COUNT: rd = {21'h0, s_r.count};
			`UCC_OFF_RESULT1: rd = {10'h0, s_r.ch[0].channel_result_value};
			`UCC_OFF_RESULT2: rd = {10'h0, s_r.ch[1].channel_result_value};
			`UCC_OFF_CLEAR: rd = '0;
			default: rresp = `UCC_RESP_SLVERR;
		endcase
		if (s_r.rvalid && i_s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (i_s_axi_arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = rd;
			s_nxt.rresp = rresp;
		end
		s_nxt.arready = !s_nxt.rvalid;

		// Main counter.
		run = s_r.counter_clock_enable && s_r.counter_enable;
		// A low-power tick is one rising edge of the synchronised slow clock.
		tick = run && (s_r.clock_source_select || (s_r.lp_s2 && !s_r.lp_prev));
		if (!run) begin
			s_nxt.count = '0;
		end else if (tick) begin
			if (s_r.count_direction_down) begin
				// Free-running down counting is unsupported and behaves as reload mode.
				if (s_r.count == '0) begin
					s_nxt.count = s_r.reload_threshold;
					hit = 1'b1;
				end else begin
					s_nxt.count = s_r.count - 11'h001;
				end
			end else if (s_r.free_running_enable) begin
				s_nxt.count = s_r.count + 11'h001;
				hit = (s_r.count == 11'h7ff);
			end else if (s_r.count == s_r.reload_threshold) begin
				s_nxt.count = '0;
				hit = 1'b1;
			end else begin
				s_nxt.count = s_r.count + 11'h001;
			end
		end
		s_nxt.timer_irq = hit && s_r.counter_irq_enable;

		// Sense channels; both may watch the same pin independently.
		for (int i = 0; i < 2; i++) begin
			sense = pin_level(s_r.gpio_s2, s_r.cfg[i].channel_pin_select);
			edge_seen = s_r.cfg[i].channel_falling_edge_select ?
				(!sense && s_r.ch[i].sense_prev) : (sense && !s_r.ch[i].sense_prev);
			s_nxt.ch[i].sense_prev = sense;
			// A clear in the same cycle as a new event loses: the event is kept.
			pending = s_r.ch[i].channel_event_flag && !clr[i];
			fire = 1'b0;
			val = '0;
			if (s_r.cfg[i].channel_counting_mode_select) begin
				if (!run) begin
					s_nxt.ch[i].cycles = '0;
					s_nxt.ch[i].edges = '0;
				end else begin
					// The tick of the closing edge counts toward the group that it ends.
					cyc = s_r.ch[i].cycles + {21'h0, tick};
					s_nxt.ch[i].cycles = cyc;
					if (edge_seen) begin
						if (s_r.ch[i].edges == s_r.cfg[i].measure_period_count) begin
							fire = 1'b1;
							val = cyc;
							s_nxt.ch[i].cycles = '0;
							s_nxt.ch[i].edges = '0;
						end else begin
							s_nxt.ch[i].edges = s_r.ch[i].edges + 8'h01;
						end
					end
				end
			end else begin
				s_nxt.ch[i].cycles = '0;
				s_nxt.ch[i].edges = '0;
				if (edge_seen) begin
					fire = 1'b1;
					val = s_r.cfg[i].snapshot_source_select ? i_rtc_value :
						{11'h0, s_r.count};
				end
			end
			// A pending event keeps its stored value; the new one only marks an overrun.
			if (fire && !pending) begin
				s_nxt.ch[i].channel_result_value = val;
			end
			s_nxt.ch[i].channel_event_flag = pending || fire;
			s_nxt.ch[i].channel_overrun_flag = (s_r.ch[i].channel_overrun_flag && !clr[i]) ||
				(fire && pending);
			// The channel interrupt follows the flag at the same edge.
			s_nxt.ch_irq[i] = s_nxt.ch[i].channel_event_flag && s_r.cfg[i].channel_irq_enable;
		end
	end

	// A low clock enable freezes every register, the bus state included.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= '0;
		end else if (i_clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign o_s_axi_awready = s_r.awready;
	assign o_s_axi_wready = s_r.wready;
	assign o_s_axi_bresp = s_r.bresp;
	assign o_s_axi_bvalid = s_r.bvalid;
	assign o_s_axi_arready = s_r.arready;
	assign o_s_axi_rdata = s_r.rdata;
	assign o_s_axi_rresp = s_r.rresp;
	assign o_s_axi_rvalid = s_r.rvalid;
	assign o_timer_irq = s_r.timer_irq;
	assign o_channel_irq = s_r.ch_irq;

endmodule // ucc_timer

`default_nettype wire

// *** ucc_timer_asserts.sv ***
// Port checker for the up/down timer with two sense channels.
`timescale 1ns/1ns
`default_nettype none
`include "ucc_defines.svh"
module ucc_timer_asserts (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [`UCC_GPIO_N-1:0] i_gpio,
	input wire logic [`UCC_ADDR_W-1:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic [1:0] o_s_axi_rresp,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_awvalid,
	input wire logic o_s_axi_awready,
	input wire logic i_s_axi_wvalid,
	input wire logic o_s_axi_wready,
	input wire logic o_s_axi_bvalid,
	input wire logic o_timer_irq,
	input wire logic [1:0] o_channel_irq
);
	default clocking dc @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);
	rd_answer_a:
	assert property (i_s_axi_arvalid && o_s_axi_arready && i_clk_en |=> o_s_axi_rvalid)
		else $error("read not answered");
	rd_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("read taken while busy");
	bad_addr_a:
	assert property (i_s_axi_arvalid && o_s_axi_arready && i_clk_en && i_s_axi_araddr > 8'h18
		|=> o_s_axi_rresp == `UCC_RESP_SLVERR && o_s_axi_rdata == 32'h0)
		else $error("unmapped read answer wrong");
	wr_answer_a:
	assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
		&& i_clk_en |-> ##2 o_s_axi_bvalid)
		else $error("write not answered");
	wr_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write taken while busy");
	out_freeze_a: assert property (!i_clk_en |=> $stable(o_timer_irq) && $stable(o_channel_irq))
		else $error("outputs moved while frozen");
	sync_delay_a:
	assert property ($rose(o_channel_irq[0]) |-> $past(i_gpio, 3) != $past(i_gpio, 4))
		else $error("channel irq at wrong delay");
	irq_hold_a: assert property ($fell(o_channel_irq[0])
		|-> o_s_axi_bvalid || $past(o_s_axi_bvalid, 1))
		else $error("channel irq dropped without write");
endmodule // ucc_timer_asserts

bind ucc_timer ucc_timer_asserts u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_clk_en(i_clk_en), .i_gpio(i_gpio), .i_s_axi_araddr(i_s_axi_araddr),
	.i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
	.o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
	.o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_awvalid(i_s_axi_awvalid),
	.o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid),
	.o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid),
	.o_timer_irq(o_timer_irq), .o_channel_irq(o_channel_irq));
`default_nettype wire

// *** ucc_pin_model.sv ***
// Pin, low-power clock and RTC source facing the timer.
`timescale 1ns/1ns
`default_nettype none
`include "ucc_defines.svh"
module ucc_pin_model (
	input wire logic i_ref_clk,
	output logic [`UCC_GPIO_N-1:0] o_gpio,
	output logic o_low_power_clock,
	output logic [`UCC_RTC_W-1:0] o_rtc_value
);
	logic [1:0] lp_r = 2'h0;
	initial begin
		o_gpio = '0;
		o_rtc_value = '0;
	end
	always @(posedge i_ref_clk) begin
		o_rtc_value <= o_rtc_value + 1'b1;
		lp_r <= lp_r + 1'b1;
	end
	// The slow clock runs free with a period of four system cycles.
	assign o_low_power_clock = lp_r[1];
	task automatic set_pin(input int idx, input logic val);
		@(posedge i_ref_clk);
		o_gpio[idx] <= val;
	endtask
endmodule // ucc_pin_model
`default_nettype wire

// *** updown_timer_capture_counter_tb.sv ***
// Self-checking bench for the up/down timer with two sense channels.
`timescale 1ns/1ns
`default_nettype none
`include "ucc_defines.svh"
module updown_timer_capture_counter_tb
	import ucc_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] awaddr = 8'h0;
	logic [7:0] araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, tirq, lpc;
	logic [1:0] bresp, rresp, cirq;
	logic [31:0] rdata;
	logic [`UCC_GPIO_N-1:0] gpio;
	logic [`UCC_RTC_W-1:0] rtc;
	int error_cnt = 0;
	int checks = 0;
	bit wave_on = 1'b0;
	logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
	logic [31:0] modes [4] = '{32'h1d005, 32'h1d805, 32'h19005, 32'h1f005};
	int gaps [4] = '{6, 6, 24, 2048};
	always #2 clk = ~clk;
	ucc_pin_model pm (.i_ref_clk(clk), .o_gpio(gpio), .o_low_power_clock(lpc), .o_rtc_value(rtc));
	ucc_timer dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_gpio(gpio),
		.i_low_power_clock(lpc), .i_rtc_value(rtc), .i_s_axi_awaddr(awaddr),
		.i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
		.o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(1'b1),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
		.o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(1'b1), .o_timer_irq(tirq), .o_channel_irq(cirq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk(32'(bresp), 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
		chk(32'(r), 32'(er));
	endtask
	// Cycles between two timer interrupt pulses.
	task automatic gap(output int n);
		while (tirq !== 1'b1) @(posedge clk);
		n = 1;
		@(posedge clk);
		while (tirq !== 1'b1) begin
			n++;
			@(posedge clk);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Square wave of period ten cycles on pin 1.
	always @(posedge clk) begin
		if (wave_on) begin
			repeat (3) @(posedge clk);
			pm.set_pin(1, ~gpio[1]);
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	initial begin
		logic [31:0] d, t;
		logic [1:0] r;
		int n;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (offs[i]) rdchk(offs[i], 32'h0);
		rdchk(8'h1c, 32'h0, `UCC_RESP_SLVERR);
		$display("reset values done");
		foreach (modes[i]) begin
			wr(`UCC_OFF_CTRL, 32'h0);
			wr(`UCC_OFF_CTRL, modes[i]);
			gap(n);
			chk(n, gaps[i]);
		end
		$display("timer periods done");
		wr(`UCC_OFF_CAPTURE, 32'h1c002c00);
		t = 32'(rtc);
		pm.set_pin(11, 1'b1);
		repeat (8) @(posedge clk);
		chk(32'(cirq), 32'h1);
		rdchk(`UCC_OFF_STATUS, 32'h3);
		rd(`UCC_OFF_RESULT2, d, r);
		// The edge t is read at, the pin-setting edge and two synchroniser stages put the snapshot four counts on.
		chk(d - t, 32'd4);
		rd(`UCC_OFF_RESULT1, t, r);
		chk(t >> 11, 32'h0);
		pm.set_pin(11, 1'b0);
		repeat (3) @(posedge clk);
		pm.set_pin(11, 1'b1);
		repeat (8) @(posedge clk);
		rdchk(`UCC_OFF_STATUS, 32'hf);
		rdchk(`UCC_OFF_RESULT1, t);
		wr(`UCC_OFF_CLEAR, 32'h3);
		rdchk(`UCC_OFF_STATUS, 32'h0);
		chk(32'(cirq), 32'h0);
		pm.set_pin(11, 1'b0);
		repeat (8) @(posedge clk);
		wr(`UCC_OFF_CAPTURE, 32'hac00);
		pm.set_pin(11, 1'b1);
		repeat (8) @(posedge clk);
		rdchk(`UCC_OFF_STATUS, 32'h0);
		pm.set_pin(11, 1'b0);
		repeat (8) @(posedge clk);
		rdchk(`UCC_OFF_STATUS, 32'h1);
		wr(`UCC_OFF_CLEAR, 32'h1);
		$display("capture done");
		wr(`UCC_OFF_CAPTURE, 32'h62030200);
		wave_on = 1'b1;
		for (n = 0; n < 2; n++) begin
			while (cirq[1] !== 1'b1) @(posedge clk);
			rd(`UCC_OFF_RESULT2, d, r);
			wr(`UCC_OFF_CLEAR, 32'h2);
			repeat (2) @(posedge clk);
		end
		chk(d, 32'd40);
		wave_on = 1'b0;
		wr(`UCC_OFF_CTRL, 32'h15005);
		rdchk(`UCC_OFF_COUNT, 32'h0);
		clk_en <= 1'b0;
		repeat (5) @(posedge clk);
		clk_en <= 1'b1;
		$display("counting and disable done");
		summarize();
	end
endmodule // updown_timer_capture_counter_tb
`default_nettype wire
